/* File: tb/ppsm_assertions.sv */
/*
 Checker for the power-state manager top ports.
 Assumes it is bound to ppsm_top and that pins are synchronised inside.
*/
`timescale 1ns/1ps
module ppsm_assertions #(
   parameter int IDLE_CYCLES = 4
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic pci_rst_n_i,
   input wire logic alt_power_on_reset_n_i,
   input wire logic bus_busy_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [15:0] cfg_rdata_o,
   input wire logic [2:0] power_state_o,
   input wire logic mem_io_decode_en_o,
   input wire logic bus_master_en_o,
   input wire logic irq_en_o,
   input wire logic link_keepalive_o,
   input wire logic deep_power_down_o,
   input wire logic standby_o,
   input wire logic device_init_o,
   input wire logic pme_n_o,
   input wire logic aux_power_sense_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // ==========================================================
   // Steps; two cycles of slack (four with PCI reset held) let registered outputs settle
   sequence low_pwr2;
      (power_state_o >= 3'd2)[*2];
   endsequence
   sequence pci_hold;
      (!pci_rst_n_i)[*4];
   endsequence
   // ==========================================================
   // Properties
   reset_values_a: assert property (disable iff (1'b0)
      (!arst_n_i)[*2] |-> device_init_o && pme_n_o &&
      power_state_o == ppsm_pkg::PPSM_D0_UNINIT) else $error("bad reset");
   low_gate_a: assert property (low_pwr2 |->
      !bus_master_en_o && !irq_en_o) else $error("master in low power");
   low_decode_a: assert property (low_pwr2 |->
      !mem_io_decode_en_o) else $error("decode in low power");
   deep_entry_a: assert property ($rose(deep_power_down_o) |->
      power_state_o inside {ppsm_pkg::PPSM_D2, ppsm_pkg::PPSM_D3})
      else $error("deep mode outside D2 or D3");
   deep_quiet_a: assert property (deep_power_down_o[*2] |->
      !link_keepalive_o) else $error("keepalive in deep mode");
   standby_state_a: assert property ($rose(standby_o) |->
      power_state_o == ppsm_pkg::PPSM_D0_ACTIVE) else $error("bad standby");
   standby_exit_a: assert property (bus_busy_i |->
      ##[1:3] !standby_o) else $error("standby kept while busy");
   pci_reset_a: assert property (pci_hold ##0
      power_state_o != ppsm_pkg::PPSM_D3 |-> ##[0:4]
      power_state_o == ppsm_pkg::PPSM_D0_UNINIT) else $error("no init");
   strap_hold_a: assert property ((pci_rst_n_i &&
      alt_power_on_reset_n_i)[*6] |-> $stable(aux_power_sense_o))
      else $error("strap changed outside reset");
   cap_read_a: assert property (cfg_rd_i &&
      cfg_addr_i == ppsm_pkg::PM_CAP_OFFSET |=> cfg_rdata_o ==
      (ppsm_pkg::PM_CAP_BASE | {aux_power_sense_o, 15'h0000}))
      else $error("bad capability value");
endmodule

bind ppsm_top ppsm_assertions #(.IDLE_CYCLES(IDLE_CYCLES)) u_chk (
   .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .pci_rst_n_i(pci_rst_n_i),
   .alt_power_on_reset_n_i(alt_power_on_reset_n_i),
   .bus_busy_i(bus_busy_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
   .cfg_rdata_o(cfg_rdata_o), .power_state_o(power_state_o),
   .mem_io_decode_en_o(mem_io_decode_en_o),
   .bus_master_en_o(bus_master_en_o), .irq_en_o(irq_en_o),
   .link_keepalive_o(link_keepalive_o),
   .deep_power_down_o(deep_power_down_o), .standby_o(standby_o),
   .device_init_o(device_init_o), .pme_n_o(pme_n_o),
   .aux_power_sense_o(aux_power_sense_o));

/* File: tb/ppsm_host_model.sv */
/*
 Host-side power logic model: pulls the shared event line up and sees
 a wake request whenever the device sinks it.
 Assumes an open-drain driver given as a level plus an enable.
*/
`timescale 1ns/1ps
module ppsm_host_model (
   input wire logic pme_n_i,
   input wire logic pme_oe_i,
   output logic pme_line_o
);
   // Pull-up wins whenever the device is not sinking the line
   assign pme_line_o = (pme_oe_i && !pme_n_i) ? 1'b0 : 1'b1;
endmodule

/* File: tb/ppsm_tb_top.sv */
/*
 Testbench for the power-state manager: a table of state writes, then
 hand tests of standby, wake, deep power-down and resets.
 Assumes the checker is bound and the host model pulls the line up.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
   failures++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
`define WAIT(c) begin for (w = 0; w < 60 && !(c); w++) #5; \
   `CHK(c, 1'b1) if (!(c)) final_report(); end
module ppsm_tb_top;
   logic ref_clk_i = 1'b0, arst_n_i, pci_rst_n_i = 1'b0, alt_n = 1'b1;
   logic strap = 1'b1, link = 1'b1, hit = 1'b0, busy = 1'b1;
   logic wr = 1'b0, rd = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000, rdata;
   logic [2:0] state;
   logic dec, bme, irq, keep, deep, stby, init, pme_n, pme_oe, aux, pme;
   int failures = 0, comparisons = 0, w, i;
   typedef struct {logic [15:0] cmd; logic [2:0] st; logic en;} ppsm_row_s;
   ppsm_row_s rows [6] = '{'{16'h0001, 3'd2, 1'b0},
      '{16'h0002, 3'd3, 1'b0}, '{16'h0003, 3'd4, 1'b0},
      '{16'h0000, 3'd1, 1'b1}, '{16'h0001, 3'd2, 1'b0},
      '{16'h0000, 3'd1, 1'b1}};

   // Bus clock well above the minimum the host must keep
   initial begin
      forever #2.5 ref_clk_i = ~ref_clk_i;
   end

   // Short idle count keeps the standby test brief
   ppsm_top #(.IDLE_CYCLES(4)) DUT (.ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i), .pci_rst_n_i(pci_rst_n_i),
      .alt_power_on_reset_n_i(alt_n), .flash_addr_aux_strap_i(strap),
      .link_valid_i(link), .packet_hit_i(hit), .cfg_wr_i(wr),
      .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .bus_busy_i(busy), .cfg_rdata_o(rdata), .power_state_o(state),
      .mem_io_decode_en_o(dec), .bus_master_en_o(bme), .irq_en_o(irq),
      .link_keepalive_o(keep), .deep_power_down_o(deep),
      .standby_o(stby), .device_init_o(init), .pme_n_o(pme_n),
      .pme_oe_o(pme_oe), .aux_power_sense_o(aux));
   ppsm_host_model u_host (.pme_n_i(pme_n), .pme_oe_i(pme_oe),
      .pme_line_o(pme));

   // ==========================================================
   // Bus tasks; samples land 1 ns after the edge
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk_i);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk_i);
      wr <= 1'b0;
      cyc(3);
   endtask
   task automatic rd16(input logic [7:0] a, input logic [15:0] e);
      @(posedge ref_clk_i);
      rd <= 1'b1;
      addr <= a;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      cyc(1);
      `CHK(rdata, e)
   endtask
   task automatic final_report();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      arst_n_i = 1'b0;
      cyc(10);
      @(posedge ref_clk_i) arst_n_i <= 1'b1;
      cyc(4);
      @(posedge ref_clk_i) pci_rst_n_i <= 1'b1;
      cyc(8);
      `CHK({state, dec}, {ppsm_pkg::PPSM_D0_UNINIT, 1'b1})
      rd16(ppsm_pkg::PM_CAP_OFFSET, ppsm_pkg::PM_CAP_BASE | 16'h8000);
      rd16(8'h40, 16'h0000);
      wr16(ppsm_pkg::CSR_BAR_OFFSET, 16'h1000);
      `CHK(state, ppsm_pkg::PPSM_D0_ACTIVE)
      $display("reset test done");
      for (i = 0; i < 6; i++) begin
         wr16(ppsm_pkg::PMCSR_OFFSET, rows[i].cmd);
         `CHK(state, rows[i].st)
         `CHK({dec, bme, irq}, {3{rows[i].en}})
      end
      $display("table test done");
      // Standby comes and goes with bus activity alone
      @(posedge ref_clk_i) busy <= 1'b0;
      `WAIT(stby === 1'b1)
      @(posedge ref_clk_i) busy <= 1'b1;
      cyc(4);
      `CHK(stby, 1'b0)
      // Link loss in the active state, then link-up and packet in D1
      wr16(ppsm_pkg::PMCSR_OFFSET, 16'h0100);
      @(posedge ref_clk_i) link <= 1'b0;
      `WAIT(pme === 1'b0)
      wr16(ppsm_pkg::PMCSR_OFFSET, 16'h8101);
      `CHK(pme, 1'b1)
      @(posedge ref_clk_i) link <= 1'b1;
      `WAIT(pme === 1'b0)
      wr16(ppsm_pkg::PMCSR_OFFSET, 16'h8101);
      @(posedge ref_clk_i) hit <= 1'b1;
      cyc(4);
      @(posedge ref_clk_i) hit <= 1'b0;
      `WAIT(pme === 1'b0)
      $display("wake test done");
      // Events disabled in D2 with the link lost: silence, deep mode
      wr16(ppsm_pkg::PMCSR_OFFSET, 16'h8002);
      @(posedge ref_clk_i) link <= 1'b0;
      cyc(20);
      `CHK(pme, 1'b1)
      `CHK({deep, keep}, 2'b10)
      wr16(ppsm_pkg::PM_DRIVER_OFFSET, 16'h0000);
      `CHK(deep, 1'b0)
      wr16(ppsm_pkg::PM_DRIVER_OFFSET, 16'h0001);
      wr16(ppsm_pkg::PMCSR_OFFSET, 16'h0103);
      `CHK(deep, 1'b1)
      @(posedge ref_clk_i) link <= 1'b1;
      `WAIT(pme === 1'b0)
      $display("deep test done");
      // In D3 only the trailing edge of bus reset initialises
      @(posedge ref_clk_i) pci_rst_n_i <= 1'b0;
      cyc(8);
      `CHK(state, ppsm_pkg::PPSM_D3)
      @(posedge ref_clk_i) pci_rst_n_i <= 1'b1;
      cyc(8);
      `CHK(state, ppsm_pkg::PPSM_D0_UNINIT)
      // Alternate reset resamples the strap, now low
      @(posedge ref_clk_i) strap <= 1'b0;
      @(posedge ref_clk_i) alt_n <= 1'b0;
      cyc(6);
      `CHK(init, 1'b1)
      @(posedge ref_clk_i) alt_n <= 1'b1;
      cyc(8);
      `CHK({state, pme}, {ppsm_pkg::PPSM_D0_UNINIT, 1'b1})
      rd16(ppsm_pkg::PM_CAP_OFFSET, ppsm_pkg::PM_CAP_BASE);
      $display("reset pins test done");
      final_report();
   end
endmodule

/* File: verilog/ppsm_if.sv */
/*
 Interface carrying link-facing events between the state core and the
 wake detector.
 Assumes both modules share ref_clk_i.
*/
`timescale 1ns/1ps
interface ppsm_wake_if;
   logic link_valid;
   logic packet_hit;
   logic arm;
   logic link_only;
   logic wake;
   modport core (output arm, output link_only, input wake,
                 output link_valid, output packet_hit);
   modport det (input arm, input link_only, output wake,
                input link_valid, input packet_hit);
endinterface

/* File: verilog/ppsm_pkg.sv */
/*
 Package for the PCI power-state manager: state encodings, register
 offsets, field positions and timing constants.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ppsm_pkg;
   // ==========================================================
   // Power states
   typedef enum logic [2:0] {
      PPSM_D0_UNINIT,
      PPSM_D0_ACTIVE,
      PPSM_D1,
      PPSM_D2,
      PPSM_D3
   } ppsm_state_e;

   // ==========================================================
   // Configuration space offsets (byte addresses)
   localparam logic [7:0] PM_CAP_OFFSET = 8'hde;
   localparam logic [7:0] PMCSR_OFFSET = 8'he0;
   localparam logic [7:0] PM_DRIVER_OFFSET = 8'he4;
   localparam logic [7:0] CSR_BAR_OFFSET = 8'h10;
   localparam logic [7:0] IO_BAR_OFFSET = 8'h14;
   localparam logic [7:0] MEM_BAR_OFFSET = 8'h18;

   // ==========================================================
   // Field positions
   localparam int PMCSR_STATE_LSB = 0;
   localparam int PMCSR_PME_EN_BIT = 8;
   localparam int PMCSR_PME_STS_BIT = 15;
   localparam int PM_DRV_DEEP_EN_BIT = 0;
   localparam int PM_CAP_D3COLD_BIT = 15;

   // Power-state field codes
   localparam logic [1:0] PS_D0 = 2'h0;
   localparam logic [1:0] PS_D1 = 2'h1;
   localparam logic [1:0] PS_D2 = 2'h2;
   localparam logic [1:0] PS_D3 = 2'h3;

   // Capability value without aux power; aux adds the D3cold bit
   localparam logic [15:0] PM_CAP_BASE = 16'h7e21;
   localparam logic [15:0] PM_DRV_RESET = 16'h0001;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int STANDBY_IDLE_NS = 1000;
   localparam int STANDBY_IDLE_CYC =
      (STANDBY_IDLE_NS * 1000) / CLK_PERIOD_PS;
endpackage

/* File: verilog/ppsm_sync.sv */
/*
 Two-flop synchroniser for a bundle of asynchronous pin levels.
 Assumes the inputs are levels held for more than two clocks.
*/
`timescale 1ns/1ps
module ppsm_sync #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   // ==========================================================
   // Synchroniser; first stage feeds only the second
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

/* File: verilog/ppsm_top.sv */
/*
 PCI power-state manager top. Tracks the uninitialized and active full
 power substates and D1, D2 and D3, gates bus mastering, interrupts
 and slave decode, raises the wake event, controls link-down deep
 power-down and reports the aux strap in the capability register.
 Assumes configuration accesses arrive as one-cycle strobes on
 ref_clk_i, and pins listed as async are synchronised here.
*/
// Behaviour
// (R1) PCI reset enters uninitialized full power
// (R2) Uninitialized: slave access and wake supported
// (R3) BAR programming moves to active state
// (R4) Host keeps bus clock above 16 MHz
// (R5) Host may stop clock via clock-run
// (R6) Active: self-managed invisible dynamic standby
// (R7) D1: no bus mastering, no interrupts
// (R8) D1: config access only, ignore memory/IO
// (R9) D1: keep link, detect wake, assert event
// (R10) D2 link down: deep mode, watch link-up
// (R11) Deep mode stops idle and integrity pulses
// (R12) Driver register bit enables deep mode
// (R13) D3 behaves like D2, bus unpowered
// (R14) Events disabled: no wake, no link upkeep
// (R15) Active: wake on link status change
// (R16) D1/D2/D3 wake rules by link validity
// (R17) Sample aux strap during either reset
// (R18) Strap alters capability register contents
// (R19) Alternate reset low initializes device
// (R20) Wake only when event enable set
// (R21) Init on reset level; D3 on trailing
// (R22) Software power-state field selects state
`timescale 1ns/1ps
module ppsm_top #(
   parameter int IDLE_CYCLES = ppsm_pkg::STANDBY_IDLE_CYC
) (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic pci_rst_n_i,
   input wire logic alt_power_on_reset_n_i,
   input wire logic flash_addr_aux_strap_i,
   input wire logic link_valid_i,
   input wire logic packet_hit_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [15:0] cfg_wdata_i,
   input wire logic bus_busy_i,
   output logic [15:0] cfg_rdata_o,
   output logic [2:0] power_state_o,
   output logic mem_io_decode_en_o,
   output logic bus_master_en_o,
   output logic irq_en_o,
   output logic link_keepalive_o,
   output logic deep_power_down_o,
   output logic standby_o,
   output logic device_init_o,
   output logic pme_n_o,
   output logic pme_oe_o,
   output logic aux_power_sense_o
);
   initial begin
      if (IDLE_CYCLES < 1) begin
         $error("IDLE_CYCLES must be at least one");
      end
   end

   // ==========================================================
   // Pin synchronisers
   logic pci_rst_n_s, alt_rst_n_s, strap_s, link_s, pkt_s;
   ppsm_sync #(.WIDTH(5)) u_sync (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .d_i({pci_rst_n_i, alt_power_on_reset_n_i,
            flash_addr_aux_strap_i, link_valid_i, packet_hit_i}),
      .q_o({pci_rst_n_s, alt_rst_n_s, strap_s, link_s, pkt_s})
   );

   ppsm_wake_if wif ();
   assign wif.link_valid = link_s;
   // Packet hits only count in low-power states
   assign wif.packet_hit = pkt_s && is_low(state_reg);  // see (R15) (R16)

   ppsm_wake_det u_det (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .w(wif.det)
   );

   ppsm_pkg::ppsm_state_e state_reg, state_next;
   logic pci_rst_prev_reg;
   logic pme_en_reg, pme_sts_reg;
   logic deep_en_reg;
   logic aux_reg;
   logic in_d3, in_low, reset_init, pci_rst_trail;
   logic wr_pmcsr, wr_bar, clr_sts;
   logic [$clog2(IDLE_CYCLES+1)-1:0] idle_cnt_reg;

   // Is the given state a low-power one
   function automatic logic is_low(ppsm_pkg::ppsm_state_e s);
      return (s == ppsm_pkg::PPSM_D1) || (s == ppsm_pkg::PPSM_D2) ||
             (s == ppsm_pkg::PPSM_D3);
   endfunction

   // ==========================================================
   // Reset qualification
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pci_rst_prev_reg <= 1'b0;
      end else begin
         pci_rst_prev_reg <= pci_rst_n_s;
      end
   end

   assign in_d3 = (state_reg == ppsm_pkg::PPSM_D3);
   assign in_low = is_low(state_reg);
   assign pci_rst_trail = pci_rst_n_s && !pci_rst_prev_reg;
   // D3 waits for PCI reset release; other states, and alt reset, init on the level
   assign reset_init = !alt_rst_n_s ||                   // see (R19)
                       (!in_d3 && !pci_rst_n_s) ||        // see (R21)
                       (in_d3 && pci_rst_trail);          // see (R21)

   // Config write decode
   always_comb begin
      wr_pmcsr = 1'b0;
      wr_bar = 1'b0;
      if (!cfg_wr_i) begin
         wr_pmcsr = 1'b0;
      end else if (cfg_addr_i == ppsm_pkg::PMCSR_OFFSET) begin
         wr_pmcsr = 1'b1;
      end else if (cfg_addr_i == ppsm_pkg::CSR_BAR_OFFSET ||
                   cfg_addr_i == ppsm_pkg::IO_BAR_OFFSET ||
                   cfg_addr_i == ppsm_pkg::MEM_BAR_OFFSET) begin
         wr_bar = 1'b1;
      end
   end

   assign clr_sts = wr_pmcsr && cfg_wdata_i[ppsm_pkg::PMCSR_PME_STS_BIT];

   // ==========================================================
   // Power state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ppsm_pkg::PPSM_D0_UNINIT: begin
            if (wr_bar) begin
               state_next = ppsm_pkg::PPSM_D0_ACTIVE;  // see (R3)
            end
         end
         default: begin
            state_next = state_reg;
         end
      endcase
      if (wr_pmcsr) begin
         case (cfg_wdata_i[ppsm_pkg::PMCSR_STATE_LSB +: 2])  // see (R22)
            ppsm_pkg::PS_D1: state_next = ppsm_pkg::PPSM_D1;
            ppsm_pkg::PS_D2: state_next = ppsm_pkg::PPSM_D2;
            ppsm_pkg::PS_D3: state_next = ppsm_pkg::PPSM_D3;
            default: begin
               if (in_low) begin
                  state_next = ppsm_pkg::PPSM_D0_ACTIVE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_reg <= ppsm_pkg::PPSM_D0_UNINIT;         // see (R1)
      end else if (reset_init) begin
         state_reg <= ppsm_pkg::PPSM_D0_UNINIT;         // see (R1)
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================
   // Event enable and driver register; enable survives PCI reset
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pme_en_reg <= 1'b0;
      end else if (!alt_rst_n_s) begin
         pme_en_reg <= 1'b0;
      end else if (wr_pmcsr) begin
         pme_en_reg <= cfg_wdata_i[ppsm_pkg::PMCSR_PME_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         deep_en_reg <= ppsm_pkg::PM_DRV_RESET[ppsm_pkg::PM_DRV_DEEP_EN_BIT];
      end else if (reset_init) begin
         deep_en_reg <= ppsm_pkg::PM_DRV_RESET[ppsm_pkg::PM_DRV_DEEP_EN_BIT];
      end else if (cfg_wr_i &&
                   cfg_addr_i == ppsm_pkg::PM_DRIVER_OFFSET) begin
         deep_en_reg <= cfg_wdata_i[ppsm_pkg::PM_DRV_DEEP_EN_BIT]; // see (R12)
      end
   end

   // Strap sampled while either reset is held
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         aux_reg <= 1'b0;
      end else if (!pci_rst_n_s || !alt_rst_n_s) begin
         aux_reg <= strap_s;                            // see (R17)
      end
   end

   // ==========================================================
   // Wake arming; deep mode listens for link-up only
   logic deep_mode;
   assign deep_mode = (state_reg == ppsm_pkg::PPSM_D2 || in_d3) &&
                      !link_s && deep_en_reg;           // see (R10) (R13)
   assign wif.arm = pme_en_reg;                         // see (R20) (R14)
   // Low-power state with link lost: link-up only, no packet filter
   assign wif.link_only = !link_s && in_low;            // see (R16)

   logic wake_ev;
   assign wake_ev = wif.wake;                  // see (R9) (R16) (R15) (R2)

   // Status: set beats clear
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pme_sts_reg <= 1'b0;
      end else if (!alt_rst_n_s) begin
         pme_sts_reg <= 1'b0;
      end else if (wake_ev) begin
         pme_sts_reg <= 1'b1;
      end else if (clr_sts) begin
         pme_sts_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Dynamic standby: idle counter, invisible to software
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idle_cnt_reg <= '0;
      end else if (state_reg != ppsm_pkg::PPSM_D0_ACTIVE ||
                   bus_busy_i) begin
         idle_cnt_reg <= '0;
      end else if (idle_cnt_reg != IDLE_CYCLES[$bits(idle_cnt_reg)-1:0]) begin
         idle_cnt_reg <= idle_cnt_reg + 1'b1;
      end
   end

   // ==========================================================
   // Registered outputs
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         power_state_o <= 3'h0;
         mem_io_decode_en_o <= 1'b0;
         bus_master_en_o <= 1'b0;
         irq_en_o <= 1'b0;
         link_keepalive_o <= 1'b0;
         deep_power_down_o <= 1'b0;
         standby_o <= 1'b0;
         device_init_o <= 1'b1;
         pme_n_o <= 1'b1;
         pme_oe_o <= 1'b0;
         aux_power_sense_o <= 1'b0;
      end else begin
         power_state_o <= state_reg;
         // D0 serves memory/IO; low states config only
         mem_io_decode_en_o <= !in_low;                 // see (R2) (R8)
         bus_master_en_o <= state_reg == ppsm_pkg::PPSM_D0_ACTIVE; // see (R7)
         irq_en_o <= !in_low;                           // see (R7)
         link_keepalive_o <= !deep_mode &&              // see (R11)
                             (!in_low || pme_en_reg);   // see (R14) (R9)
         deep_power_down_o <= deep_mode;                // see (R10)
         standby_o <= idle_cnt_reg ==
                      IDLE_CYCLES[$bits(idle_cnt_reg)-1:0]; // see (R6) (R5)
         device_init_o <= reset_init;                   // see (R21)
         pme_n_o <= !(pme_sts_reg && pme_en_reg);       // see (R9)
         pme_oe_o <= pme_sts_reg && pme_en_reg;
         aux_power_sense_o <= aux_reg;
      end
   end

   // Config read data
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cfg_rdata_o <= 16'h0000;
      end else if (!cfg_rd_i) begin
         cfg_rdata_o <= cfg_rdata_o;
      end else if (cfg_addr_i == ppsm_pkg::PM_CAP_OFFSET) begin
         cfg_rdata_o <= ppsm_pkg::PM_CAP_BASE |              // see (R18)
                        ({15'h0000, aux_reg} << ppsm_pkg::PM_CAP_D3COLD_BIT);
      end else if (cfg_addr_i == ppsm_pkg::PMCSR_OFFSET) begin
         cfg_rdata_o <= {pme_sts_reg, 6'h00, pme_en_reg, 6'h00,
                         power_code(state_reg)};
      end else if (cfg_addr_i == ppsm_pkg::PM_DRIVER_OFFSET) begin
         cfg_rdata_o <= {15'h0000, deep_en_reg};
      end else begin
         cfg_rdata_o <= 16'h0000;
      end
   end

   // Map internal state to the two-bit field
   function automatic logic [1:0] power_code(ppsm_pkg::ppsm_state_e s);
      case (s)
         ppsm_pkg::PPSM_D1: return ppsm_pkg::PS_D1;
         ppsm_pkg::PPSM_D2: return ppsm_pkg::PS_D2;
         ppsm_pkg::PPSM_D3: return ppsm_pkg::PS_D3;
         default: return ppsm_pkg::PS_D0;
      endcase
   endfunction
endmodule

/* File: verilog/ppsm_wake_det.sv */
/*
 Wake-event detector: link status change and packet hits.
 Assumes synchronised link inputs and an arm level from the core.
*/
`timescale 1ns/1ps
module ppsm_wake_det (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   ppsm_wake_if.det w
);
   logic link_prev_reg;
   logic link_change;

   // ==========================================================
   // Previous link level for change detection
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_prev_reg <= 1'b0;
      end else begin
         link_prev_reg <= w.link_valid;
      end
   end

   // Change in either direction is a candidate event
   assign link_change = w.link_valid ^ link_prev_reg;

   // A low-power state with the link lost only listens for link returning
   always_comb begin
      if (!w.arm) begin
         w.wake = 1'b0;
      end else if (w.link_only) begin
         w.wake = link_change && w.link_valid;
      end else begin
         w.wake = link_change || w.packet_hit;
      end
   end
endmodule
